// ### verilog/fes_top.sv
// fault escalation, lockup and sleep control with apb register access
`timescale 1ns/1ps
module fes_top
  import fes_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fes_fault_s fault,
  input wire fes_ctx_s ctx,
  input wire fes_core_s core,
  output logic excReq,
  output fes_class_e excClass,
  output logic lockup,
  output logic execHalt,
  output logic cpuClkOff,
  output logic sysClkOff,
  output logic pllFlashOff,
  output logic handlerDefer
);
  typedef struct packed {
    logic [1:0] hard;
    logic [3:0] mm;
    logic mmValid;
    logic [31:0] memmanage_fault_address;
    logic [4:0] bus;
    logic busValid;
    logic [31:0] busAddr;
    logic [5:0] useFlags;
    logic [2:0] priMm;
    logic [2:0] priBus;
    logic [2:0] priUse;
    logic [2:0] handlerEn;
    logic sleepOnExit;
    logic deepSel;
    logic evtOnPend;
    logic evtLatch;
    fes_state_e mode;
    logic lockFromNmi;
    logic excReq;
    fes_class_e excCls;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic defer;
    logic cpuOff;
    logic sysOff;
    logic pllOff;
    logic lockOut;
    logic haltOut;
  } fes_st_s;

  fes_st_s st_q;
  fes_st_s st_d;
  fes_dec_s dec;
  logic access;
  logic commit;
  logic wr;
  logic [31:0] rd;
  logic hit;
  logic take;
  logic sleeping;
  logic wakeInt;
  logic wakeEvt;

  fes_fault_sort u_sort (
    .flt(fault),
    .ctx(ctx),
    .priMm(st_q.priMm),
    .priBus(st_q.priBus),
    .priUse(st_q.priUse),
    .handlerEn(st_q.handlerEn),
    .dec(dec)
  );

  always_comb begin
    st_d = st_q;
    access = psel && penable;
    commit = access && st_q.pready;
    wr = commit && pwrite;
    take = dec.cls != CLS_NONE && st_q.mode != ST_LOCK;
    sleeping = st_q.mode == ST_SLP_INT || st_q.mode == ST_SLP_EVT ||
      st_q.mode == ST_SLP_EXIT;
    wakeInt = core.entryReady;
    wakeEvt = core.entryReady || (st_q.evtOnPend && core.newPending) || core.sevInstr;

    // address decode, read mux
    hit = 1'b1;
    rd = 32'h0;
    unique case (paddr)
      OFF_HARD: begin
        rd[HF_VEC] = st_q.hard[0];
        rd[HF_ESC] = st_q.hard[1];
      end
      OFF_MM: begin
        rd[3:0] = st_q.mm;
        rd[MM_AVALID] = st_q.mmValid;
      end
      OFF_BUS: begin
        rd[4:0] = st_q.bus;
        rd[BF_AVALID] = st_q.busValid;
      end
      OFF_USE: begin
        rd[5:0] = st_q.useFlags;
      end
      OFF_MMADR: begin
        rd = st_q.memmanage_fault_address;
      end
      OFF_BUSADR: begin
        rd = st_q.busAddr;
      end
      OFF_PRI: begin
        rd[PRI_MM +: 3] = st_q.priMm;
        rd[PRI_BUS +: 3] = st_q.priBus;
        rd[PRI_USE +: 3] = st_q.priUse;
      end
      OFF_EN: begin
        rd[2:0] = st_q.handlerEn;
      end
      OFF_SLP: begin
        // event latch deliberately absent from the map
        rd[SC_EXIT] = st_q.sleepOnExit;
        rd[SC_DEEP] = st_q.deepSel;
        rd[SC_SEVPEND] = st_q.evtOnPend;
      end
      OFF_CORE: begin
        rd[CS_LOCK] = st_q.mode == ST_LOCK;
        rd[CS_SLEEP] = sleeping;
        rd[CS_DEEP] = sleeping && st_q.deepSel;
        rd[CS_LOCKNMI] = st_q.lockFromNmi;
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    // one wait state: ready rises on the cycle after the access phase opens
    st_d.pready = access && !st_q.pready;
    if (access && !st_q.pready) begin
      st_d.prdata = pwrite ? 32'h0 : rd;
      st_d.pslverr = !hit;
    end

    // software side: status flags write one to clear, set below wins
    if (wr && hit) begin
      unique case (paddr)
        OFF_HARD: begin
          st_d.hard = st_q.hard & ~{pwdata[HF_ESC], pwdata[HF_VEC]};
        end
        OFF_MM: begin
          st_d.mm = st_q.mm & ~pwdata[3:0];
          st_d.mmValid = st_q.mmValid & ~pwdata[MM_AVALID];
        end
        OFF_BUS: begin
          st_d.bus = st_q.bus & ~pwdata[4:0];
          st_d.busValid = st_q.busValid & ~pwdata[BF_AVALID];
        end
        OFF_USE: begin
          st_d.useFlags = st_q.useFlags & ~pwdata[5:0];
        end
        OFF_PRI: begin
          st_d.priMm = pwdata[PRI_MM +: 3];
          st_d.priBus = pwdata[PRI_BUS +: 3];
          st_d.priUse = pwdata[PRI_USE +: 3];
        end
        OFF_EN: begin
          st_d.handlerEn = pwdata[2:0];
        end
        OFF_SLP: begin
          st_d.sleepOnExit = pwdata[SC_EXIT];
          st_d.deepSel = pwdata[SC_DEEP];
          st_d.evtOnPend = pwdata[SC_SEVPEND];
        end
        default: begin
        end
      endcase
    end

    // fault capture; flags stick until cleared
    st_d.excReq = 1'b0;
    if (take) begin
      st_d.excReq = !dec.lockup;
      st_d.excCls = dec.cls;
      st_d.hard[0] = st_d.hard[0] | dec.vecSet;
      st_d.hard[1] = st_d.hard[1] | dec.escalate;
      st_d.mm = st_d.mm | dec.mmSet;
      st_d.bus = st_d.bus | dec.busSet;
      st_d.useFlags = st_d.useFlags | dec.useSet;
      // first address kept; a later fault must not overwrite an unread one
      if (|dec.mmSet && !st_d.mmValid) begin
        st_d.memmanage_fault_address = fault.addr;
        st_d.mmValid = 1'b1;
      end
      if (|dec.busSet && !st_d.busValid) begin
        st_d.busAddr = fault.addr;
        st_d.busValid = 1'b1;
      end
    end

    // event latch: set wins over the clear by a wait for event
    if (st_q.mode == ST_RUN && core.wfeInstr && st_q.evtLatch) begin
      st_d.evtLatch = 1'b0;
    end
    if (core.sevInstr || (st_q.evtOnPend && core.newPending)) begin
      st_d.evtLatch = 1'b1;
    end

    // sleep and lockup sequencing
    unique case (st_q.mode)
      ST_RUN: begin
        if (core.wfiInstr && !core.entryReady) begin
          st_d.mode = ST_SLP_INT;
        end else if (core.wfeInstr && !st_q.evtLatch) begin
          st_d.mode = ST_SLP_EVT;
        end else if (core.returnToThread && st_q.sleepOnExit && !core.entryReady) begin
          st_d.mode = ST_SLP_EXIT;
        end
      end
      ST_SLP_INT, ST_SLP_EXIT: begin
        if (wakeInt) begin
          st_d.mode = ST_RUN;
          st_d.defer = core.interrupt_priority_mask;
        end
      end
      ST_SLP_EVT: begin
        if (wakeEvt) begin
          st_d.mode = ST_RUN;
          st_d.evtLatch = 1'b0;
        end
      end
      ST_LOCK: begin
        if (core.debugHalt || (core.nmiTaken && !st_q.lockFromNmi)) begin
          st_d.mode = ST_RUN;
          st_d.lockFromNmi = 1'b0;
        end
      end
      default: begin
        st_d.mode = ST_RUN;
      end
    endcase
    if (take && dec.lockup) begin
      st_d.mode = ST_LOCK;
      st_d.lockFromNmi = ctx.inNmi;
    end
    if (!core.interrupt_priority_mask) begin
      st_d.defer = 1'b0;
    end

    // clock gating follows the mode of the next cycle
    st_d.cpuOff = st_d.mode == ST_SLP_INT || st_d.mode == ST_SLP_EVT ||
      st_d.mode == ST_SLP_EXIT;
    st_d.sysOff = st_d.cpuOff && st_q.deepSel;
    st_d.pllOff = st_d.cpuOff && st_q.deepSel;
    // registered copies so the pins carry no decode glitch
    st_d.lockOut = st_d.mode == ST_LOCK;
    st_d.haltOut = st_d.mode != ST_RUN;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.mode <= ST_RUN;
      st_q.excCls <= CLS_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign excReq = st_q.excReq;
  assign excClass = st_q.excCls;
  assign lockup = st_q.lockOut;
  assign execHalt = st_q.haltOut;
  assign cpuClkOff = st_q.cpuOff;
  assign sysClkOff = st_q.sysOff;
  assign pllFlashOff = st_q.pllOff;
  assign handlerDefer = st_q.defer;
endmodule

// ### verilog/fes_pkg.sv
// constants and types for the fault escalation and sleep control block
// Operation
// - bus errors, internal errors, non-executable fetches and protection violations raise faults
// - vector read bus error goes to hard fault and sets vector read flag
// - escalated configurable fault takes hard fault and sets escalated flag
// - protection mismatches set instruction, data, push or pop violation flags
// - non-executable fetch sets instruction violation even with protection off
// - stacking, unstacking, prefetch, precise, inexact bus errors set bus fault flags
// - seven usage fault causes set six flags; two of them share one
// - foreign instruction set and bad continuation return both mean invalid state
// - non-hard faults have programmable priority and individual handler enables
// - equal or lower priority fault in handler, or disabled handler, escalates
// - bus fault pushing for bus handler entry does not escalate
// - hard fault yields only to reset and nmi, preempts everything else
// - bus and memory faults capture the accessed address
// - hard fault inside nmi or hard fault handler enters lockup
// - lockup ends on reset, debug halt or nmi unless entered from nmi
// - deep select chooses mode; sleep gates cpu clock, deep stops more
// - wait for interrupt sleeps at once unless wake already true
// - wait for event sleeps if latch clear, else clears latch and continues
// - send event sets latch; software cannot read or write it
// - sleep on exit sleeps on return to thread after all handlers
// - interrupt wake only on entry-able exception; priority mask defers handler
// - event wake on entry-able exception, or any new pending with event-on-pending
// - return value valid only with top bits set and nibble 1, 9 or d
// - equal priority exception never preempts, it stays pending
package fes_pkg;
  localparam logic [7:0] OFF_HARD = 8'h00;
  localparam logic [7:0] OFF_MM = 8'h04;
  localparam logic [7:0] OFF_BUS = 8'h08;
  localparam logic [7:0] OFF_USE = 8'h0c;
  localparam logic [7:0] OFF_MMADR = 8'h10;
  localparam logic [7:0] OFF_BUSADR = 8'h14;
  localparam logic [7:0] OFF_PRI = 8'h18;
  localparam logic [7:0] OFF_EN = 8'h1c;
  localparam logic [7:0] OFF_SLP = 8'h20;
  localparam logic [7:0] OFF_CORE = 8'h24;
  localparam int HF_VEC = 1;
  localparam int HF_ESC = 30;
  localparam int MM_AVALID = 7;
  localparam int BF_AVALID = 7;
  localparam int PRI_MM = 0;
  localparam int PRI_BUS = 8;
  localparam int PRI_USE = 16;
  localparam int EN_MM = 0;
  localparam int EN_BUS = 1;
  localparam int EN_USE = 2;
  localparam int SC_EXIT = 1;
  localparam int SC_DEEP = 2;
  localparam int SC_SEVPEND = 4;
  localparam int CS_LOCK = 0;
  localparam int CS_SLEEP = 1;
  localparam int CS_DEEP = 2;
  localparam int CS_LOCKNMI = 3;
  localparam logic [27:0] RET_TOP = 28'hfffffff;
  localparam logic [3:0] RET_HND = 4'h1;
  localparam logic [3:0] RET_MSP = 4'h9;
  localparam logic [3:0] RET_PSP = 4'hd;
  typedef struct packed {
    logic [31:0] addr;
    logic vecRead;
    logic mmInstr;
    logic mmData;
    logic mmPush;
    logic mmPop;
    logic xnFetch;
    logic busPush;
    logic busPop;
    logic busFetch;
    logic busPrecise;
    logic busInexact;
    logic no_coprocessor_flag;
    logic undefined_instr_flag;
    logic foreignIsa;
    logic iciBadReturn;
    logic misalign;
    logic zeroDiv;
    logic retCheck;
    logic [31:0] retValue;
  } fes_fault_s;
  typedef struct packed {
    logic inHandler;
    logic inNmi;
    logic inHardFault;
    logic enteringBus;
    logic [2:0] curPrio;
  } fes_ctx_s;
  typedef struct packed {
    logic wfiInstr;
    logic wfeInstr;
    logic sevInstr;
    logic returnToThread;
    logic entryReady;
    logic newPending;
    logic interrupt_priority_mask;
    logic nmiTaken;
    logic debugHalt;
  } fes_core_s;
  typedef enum logic [4:0] {
    CLS_NONE = 5'b00001,
    CLS_HARD = 5'b00010,
    CLS_MM = 5'b00100,
    CLS_BUS = 5'b01000,
    CLS_USE = 5'b10000
  } fes_class_e;
  typedef struct packed {
    fes_class_e cls;
    logic escalate;
    logic lockup;
    logic vecSet;
    logic [3:0] mmSet;
    logic [4:0] busSet;
    logic [5:0] useSet;
  } fes_dec_s;
  typedef enum logic [4:0] {
    ST_RUN = 5'b00001,
    ST_SLP_INT = 5'b00010,
    ST_SLP_EVT = 5'b00100,
    ST_SLP_EXIT = 5'b01000,
    ST_LOCK = 5'b10000
  } fes_state_e;
endpackage

// ### verilog/fes_fault_sort.sv
// fault classifier: cause flags, handler class and escalation
`timescale 1ns/1ps
module fes_fault_sort
  import fes_pkg::*;
(
  input wire fes_fault_s flt,
  input wire fes_ctx_s ctx,
  input wire logic [2:0] priMm,
  input wire logic [2:0] priBus,
  input wire logic [2:0] priUse,
  input wire logic [2:0] handlerEn,
  output fes_dec_s dec
);
  logic retBad;
  logic [2:0] prio;
  logic en;
  logic cfg;
  logic noEsc;
  always_comb begin
    retBad = flt.retCheck && !(flt.retValue[31:4] == RET_TOP &&
      (flt.retValue[3:0] == RET_HND || flt.retValue[3:0] == RET_MSP ||
       flt.retValue[3:0] == RET_PSP));
    dec.vecSet = flt.vecRead;
    dec.mmSet = {flt.mmPop, flt.mmPush, flt.mmData, flt.mmInstr | flt.xnFetch};
    dec.busSet = {flt.busInexact, flt.busPrecise, flt.busFetch, flt.busPop, flt.busPush};
    dec.useSet = {flt.zeroDiv, flt.misalign, retBad, flt.foreignIsa | flt.iciBadReturn,
      flt.undefined_instr_flag, flt.no_coprocessor_flag};
    prio = priUse;
    en = handlerEn[EN_USE];
    noEsc = 1'b0;
    dec.cls = CLS_NONE;
    if (dec.vecSet) begin
      dec.cls = CLS_HARD;
    end else if (|dec.mmSet) begin
      dec.cls = CLS_MM;
      prio = priMm;
      en = handlerEn[EN_MM];
    end else if (|dec.busSet) begin
      dec.cls = CLS_BUS;
      prio = priBus;
      en = handlerEn[EN_BUS];
      noEsc = flt.busPush && ctx.enteringBus;
    end else if (|dec.useSet) begin
      dec.cls = CLS_USE;
    end
    cfg = dec.cls != CLS_NONE && dec.cls != CLS_HARD;
    // nmi and hard fault sit above every programmable level
    dec.escalate = cfg && !noEsc && (!en || ctx.inNmi || ctx.inHardFault ||
      (ctx.inHandler && prio >= ctx.curPrio));
    if (dec.escalate) begin
      dec.cls = CLS_HARD;
    end
    dec.lockup = dec.cls == CLS_HARD && (ctx.inNmi || ctx.inHardFault);
  end
endmodule

// ### bench/fes_assertions.sv
// port-level checks for the fault escalation and sleep block
`timescale 1ns/1ps
module fes_assertions
  import fes_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire fes_fault_s fault,
  input wire fes_ctx_s ctx,
  input wire fes_core_s core,
  input wire logic excReq,
  input wire fes_class_e excClass,
  input wire logic lockup,
  input wire logic execHalt,
  input wire logic cpuClkOff,
  input wire logic sysClkOff,
  input wire logic pllFlashOff
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  logic calm;
  // neither nmi nor hard handler running, so no lockup path
  assign calm = !ctx.inNmi && !ctx.inHardFault && !lockup;
  property p_vec;
    fault.vecRead && calm |=> excReq && excClass == CLS_HARD;
  endproperty
  a_vec: assert property (p_vec) else $error("vector error not sent to hard class");
  // any memory cause outranks the bus class, so all of them are excluded
  property p_bpush;
    fault.busPush && ctx.enteringBus && calm && !fault.vecRead &&
      !(fault.mmInstr || fault.mmData || fault.mmPush || fault.mmPop || fault.xnFetch)
      |=> excReq && excClass == CLS_BUS;
  endproperty
  a_bpush: assert property (p_bpush) else $error("bus push escalated");
  property p_lock_in;
    fault.vecRead && (ctx.inNmi || ctx.inHardFault) && !lockup |=> lockup && !excReq;
  endproperty
  a_lock_in: assert property (p_lock_in) else $error("no lockup on nested hard fault");
  property p_lock_hold;
    lockup && !core.debugHalt && !core.nmiTaken |=> lockup;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockup left without cause");
  property p_halt;
    lockup || cpuClkOff |-> execHalt;
  endproperty
  a_halt: assert property (p_halt) else $error("execution not halted");
  property p_deep;
    sysClkOff |-> cpuClkOff && pllFlashOff;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep outputs disagree");
  property p_wfi;
    core.wfiInstr && !core.entryReady && !execHalt |=> cpuClkOff;
  endproperty
  a_wfi: assert property (p_wfi) else $error("no sleep after wait for interrupt");
  property p_wake;
    cpuClkOff && core.entryReady |=> !cpuClkOff && !execHalt;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on entry request");
  sequence s_sev_wfe;
    core.sevInstr && !execHalt ##1 core.wfeInstr;
  endsequence
  property p_sev;
    s_sev_wfe |=> !cpuClkOff;
  endproperty
  a_sev: assert property (p_sev) else $error("slept with event latch set");
  c_lock: cover property (lockup);
  c_deep: cover property (sysClkOff);
  c_use: cover property (excReq && excClass == CLS_USE);
endmodule
bind fes_top fes_assertions i_fes_assertions(.sys_clk, .resetn, .fault, .ctx, .core, .excReq, .excClass,
  .lockup, .execHalt, .cpuClkOff, .sysClkOff, .pllFlashOff);

// ### bench/fes_irq_model.sv
// interrupt controller stand-in: raises entry request after a set latency
`timescale 1ns/1ps
module fes_irq_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic arm,
  input wire logic drop,
  input wire logic [7:0] lat,
  output logic entryReady
);
  logic [7:0] cnt_q;
  logic busy_q;
  // request stays up until the core side takes it, like a real pending line
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h0;
      busy_q <= 1'h0;
      entryReady <= 1'h0;
    end else if (drop) begin
      busy_q <= 1'h0;
      entryReady <= 1'h0;
    end else if (arm) begin
      busy_q <= 1'h1;
      cnt_q <= lat;
    end else if (busy_q && cnt_q == 8'h0) begin
      busy_q <= 1'h0;
      entryReady <= 1'h1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h1;
    end
  end
endmodule

// ### bench/fes_top_tb.sv
// self-checking bench for the fault escalation and sleep block
`timescale 1ns/1ps
module fes_top_tb
  import fes_pkg::*;
;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, excReq;
  logic lockup, execHalt, cpuClkOff, sysClkOff, pllFlashOff, handlerDefer;
  logic arm, drop, entryReady, lastErr;
  logic [7:0] paddr, lat;
  logic [31:0] pwdata, prdata, rdv;
  logic [81:0] fv;
  fes_fault_s fault;
  fes_ctx_s ctx;
  fes_core_s coreIn, core;
  fes_class_e excClass;
  int mismatches, n_compared;
  logic [31:0] rv [5] = '{32'hfffffff1, 32'hfffffff9, 32'hfffffffd, 32'hfffffffe, 32'h7ffffff9};
  fes_top i_fes_top(.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fault, .ctx, .core, .excReq, .excClass, .lockup, .execHalt, .cpuClkOff, .sysClkOff, .pllFlashOff,
    .handlerDefer);
  fes_irq_model i_fes_irq_model(.sys_clk, .resetn, .arm, .drop, .lat, .entryReady);
  always_comb begin
    core = coreIn;
    core.entryReady = entryReady;
  end
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  task stop_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rdv = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(rdv === e, "register read mismatch");
  endtask
  // one-cycle cause pulse; bit index into the fault struct
  task shot(input int p, input logic [31:0] v);
    fv = '0;
    fv[p] = 1'h1;
    fv[81:50] = v;
    fv[31:0] = v;
    @(posedge sys_clk);
    fault <= fes_fault_s'(fv);
    @(posedge sys_clk);
    fault <= '0;
    #1;
  endtask
  task hit(input int p, input fes_class_e c, input logic [7:0] o, input logic [31:0] m);
    logic ad;
    ad = (c == CLS_MM || c == CLS_BUS);
    shot(p, 32'hc0de0000 + p);
    chk(excReq === 1'h1 && excClass === c, "wrong handler class");
    rd(o, m | (ad ? 32'h80 : 32'h0));
    if (ad) rd(o + 8'h0c, 32'hc0de0000 + p);
    xfer(1'h1, o, 32'hffffffff);
  endtask
  task tick(input int b);
    @(posedge sys_clk);
    coreIn[b] <= 1'h1;
    @(posedge sys_clk);
    coreIn[b] <= 1'h0;
    #1;
  endtask
  task wake(input logic [7:0] l);
    int n;
    @(posedge sys_clk);
    arm <= 1'h1;
    lat <= l;
    @(posedge sys_clk);
    arm <= 1'h0;
    n = 0;
    while (cpuClkOff !== 1'h0 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n < 40 && execHalt === 1'h0, "no wake");
    @(posedge sys_clk);
    drop <= 1'h1;
    @(posedge sys_clk);
    drop <= 1'h0;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    {resetn, psel, penable, pwrite, arm, drop} = 6'h0;
    {paddr, pwdata, lat} = '0;
    fault = '0;
    ctx = '0;
    coreIn = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    #1 chk(excClass === CLS_NONE && lockup === 1'h0, "reset state");
    rd(8'h1c, 32'h0);
    xfer(1'h1, 8'h1c, 32'h7);
    rd(8'h1c, 32'h7);
    xfer(1'h1, 8'h18, 32'h00020103);
    rd(8'h18, 32'h00020103);
    xfer(1'h0, 8'h3c, 32'h0);
    chk(lastErr === 1'h1 && rdv === 32'h0, "unmapped access");
    hit(49, CLS_HARD, 8'h00, 32'h2);
    hit(48, CLS_MM, 8'h04, 32'h1);
    hit(47, CLS_MM, 8'h04, 32'h2);
    hit(46, CLS_MM, 8'h04, 32'h4);
    hit(45, CLS_MM, 8'h04, 32'h8);
    hit(44, CLS_MM, 8'h04, 32'h1);
    hit(43, CLS_BUS, 8'h08, 32'h1);
    hit(42, CLS_BUS, 8'h08, 32'h2);
    hit(41, CLS_BUS, 8'h08, 32'h4);
    hit(40, CLS_BUS, 8'h08, 32'h8);
    hit(39, CLS_BUS, 8'h08, 32'h10);
    hit(38, CLS_USE, 8'h0c, 32'h1);
    hit(37, CLS_USE, 8'h0c, 32'h2);
    hit(36, CLS_USE, 8'h0c, 32'h4);
    hit(35, CLS_USE, 8'h0c, 32'h4);
    hit(34, CLS_USE, 8'h0c, 32'h10);
    hit(33, CLS_USE, 8'h0c, 32'h20);
    // handler at priority 2, usage also 2: equal level must escalate
    @(posedge sys_clk);
    ctx <= fes_ctx_s'(7'h42);
    shot(37, 32'h0);
    chk(excClass === CLS_HARD, "equal priority not escalated");
    rd(8'h00, 32'h40000000);
    rd(8'h0c, 32'h2);
    xfer(1'h1, 8'h00, 32'hffffffff);
    @(posedge sys_clk);
    ctx <= fes_ctx_s'(7'h43);
    shot(37, 32'h0);
    chk(excClass === CLS_USE, "higher priority escalated");
    @(posedge sys_clk);
    ctx <= fes_ctx_s'(7'h49);
    shot(43, 32'h0);
    chk(excClass === CLS_BUS, "bus push escalated");
    @(posedge sys_clk);
    ctx <= '0;
    xfer(1'h1, 8'h1c, 32'h3);
    shot(33, 32'h0);
    chk(excClass === CLS_HARD, "disabled handler not escalated");
    rd(8'h00, 32'h40000000);
    xfer(1'h1, 8'h1c, 32'h7);
    xfer(1'h1, 8'h0c, 32'hffffffff);
    for (int i = 0; i < 5; i++) begin
      shot(32, rv[i]);
      chk(excReq === (i > 2), "return value check");
    end
    rd(8'h0c, 32'h8);
    @(posedge sys_clk);
    ctx <= fes_ctx_s'(7'h10);
    shot(49, 32'h0);
    chk(excReq === 1'h0 && lockup === 1'h1, "no lockup");
    shot(40, 32'h0);
    chk(excReq === 1'h0, "fault taken in lockup");
    rd(8'h24, 32'h1);
    tick(1);
    chk(lockup === 1'h0, "nmi did not release");
    @(posedge sys_clk);
    ctx <= fes_ctx_s'(7'h20);
    shot(49, 32'h0);
    rd(8'h24, 32'h9);
    tick(1);
    chk(lockup === 1'h1, "nmi released nmi lockup");
    tick(0);
    chk(lockup === 1'h0, "halt did not release");
    @(posedge sys_clk);
    ctx <= '0;
    tick(5);
    chk(cpuClkOff === 1'h0, "slept on exit while disabled");
    tick(8);
    chk(cpuClkOff === 1'h1 && execHalt === 1'h1 && sysClkOff === 1'h0, "no sleep");
    wake(8'h10);
    // zero latency so the entry request stands before the wait for interrupt
    @(posedge sys_clk);
    arm <= 1'h1;
    lat <= 8'h0;
    @(posedge sys_clk);
    arm <= 1'h0;
    repeat (3) @(posedge sys_clk);
    tick(8);
    chk(cpuClkOff === 1'h0, "slept with wake pending");
    wake(8'h0);
    xfer(1'h1, 8'h20, 32'h4);
    tick(8);
    chk(sysClkOff === 1'h1 && pllFlashOff === 1'h1, "no deep sleep");
    rd(8'h24, 32'h6);
    wake(8'h0);
    // priority mask held: wake must still happen, entry deferred
    @(posedge sys_clk);
    coreIn.interrupt_priority_mask <= 1'h1;
    tick(8);
    wake(8'h2);
    chk(handlerDefer === 1'h1, "handler not deferred");
    @(posedge sys_clk);
    coreIn.interrupt_priority_mask <= 1'h0;
    @(posedge sys_clk);
    #1 chk(handlerDefer === 1'h0, "defer not released");
    xfer(1'h1, 8'h20, 32'h0);
    tick(7);
    chk(cpuClkOff === 1'h1, "no sleep on clear latch");
    tick(6);
    chk(cpuClkOff === 1'h0, "event did not wake");
    @(posedge sys_clk);
    coreIn.sevInstr <= 1'h1;
    @(posedge sys_clk);
    coreIn.sevInstr <= 1'h0;
    coreIn.wfeInstr <= 1'h1;
    @(posedge sys_clk);
    coreIn.wfeInstr <= 1'h0;
    #1 chk(cpuClkOff === 1'h0, "slept with latch set");
    tick(7);
    chk(cpuClkOff === 1'h1, "latch not cleared");
    tick(3);
    chk(cpuClkOff === 1'h1, "pending woke without enable bit");
    xfer(1'h1, 8'h20, 32'h10);
    tick(3);
    chk(cpuClkOff === 1'h0, "pending did not wake");
    xfer(1'h1, 8'h20, 32'h2);
    tick(5);
    chk(cpuClkOff === 1'h1, "no sleep on exit");
    wake(8'h4);
    stop_test();
  end
endmodule
